//--- rtl/lro_exec_map.vh
// Constants for the literal, return, option and no-op executor
// How it works
// RULE1: Return-with-literal loads literal into work register
// RULE2: Return-with-literal pops stack top into counter
// RULE3: Return-with-literal takes two cycles, one word
// RULE4: Load-option copies work into option, one cycle
// RULE5: Move-literal loads work; all-zero word idles
`ifndef LRO_EXEC_MAP_VH
`define LRO_EXEC_MAP_VH
`define LRO_OP_RETLIT    4'h8
`define LRO_OP_MOVLIT    4'hc
`define LRO_WORD_OPTION  12'h002
`define LRO_WORD_NOP     12'h000
`define LRO_OP_MSB       11
`define LRO_OP_LSB       8
`define LRO_LIT_MSB      7
`define LRO_RST_WORK     8'h00
`define LRO_RST_OPTION   8'hff
`define LRO_RST_PC       11'h000
`endif

//--- rtl/lro_decode.v
// Combinational decoder for the four instruction kinds
`timescale 1ns/1ps
`include "lro_exec_map.vh"
module lro_decode (
  input  wire [11:0] i_word,
  output wire        o_retlit,
  output wire        o_movlit,
  output wire        o_option,
  output wire        o_nop,
  output wire [7:0]  o_lit
);
  assign o_retlit = (i_word[`LRO_OP_MSB:`LRO_OP_LSB] == `LRO_OP_RETLIT);
  assign o_movlit = (i_word[`LRO_OP_MSB:`LRO_OP_LSB] == `LRO_OP_MOVLIT);
  assign o_option = (i_word == `LRO_WORD_OPTION);
  assign o_nop    = (i_word == `LRO_WORD_NOP);
  assign o_lit    = i_word[`LRO_LIT_MSB:0];
endmodule

//--- rtl/lro_exec.v
// Executor for literal load, literal return, option load and no-op
`timescale 1ns/1ps
`include "lro_exec_map.vh"
module lro_exec #(
  parameter PC_W = 11
) (
  input  wire            i_clk,
  input  wire            i_rst_n,
  input  wire            i_valid,
  input  wire [11:0]     i_word,
  input  wire [PC_W-1:0] i_stack_top_entry,
  output wire [7:0]      o_work,
  output wire [7:0]      o_option,
  output wire [PC_W-1:0] o_pc,
  output wire            o_pc_load,
  output wire            o_stack_pop,
  output wire            o_busy,
  output wire            o_done
);
  localparam ST_IDLE  = 1'b0;
  localparam ST_FLUSH = 1'b1;

  // Decoded instruction kind
  wire            dec_ret;
  wire            dec_mov;
  wire            dec_opt;
  wire            dec_nop;
  wire [7:0]      dec_lit;

  // State and register storage
  reg             state_r;
  reg             state_nxt;
  reg  [7:0]      work_r;
  reg  [7:0]      work_nxt;
  reg  [7:0]      option_r;
  reg  [7:0]      option_nxt;
  reg  [PC_W-1:0] pc_r;
  reg  [PC_W-1:0] pc_nxt;
  reg             pc_load_r;
  reg             pc_load_nxt;
  reg             stack_pop_r;
  reg             stack_pop_nxt;
  reg             busy_r;
  reg             busy_nxt;
  reg             done_r;
  reg             done_nxt;

  // Instruction acceptance
  wire            take;
  wire            take_ret;
  wire            take_mov;
  wire            take_opt;
  wire            take_nop;

  lro_decode u_dec (
    .i_word   (i_word),
    .o_retlit (dec_ret),
    .o_movlit (dec_mov),
    .o_option (dec_opt),
    .o_nop    (dec_nop),
    .o_lit    (dec_lit)
  );

  assign take     = i_valid && (state_r == ST_IDLE);
  assign take_ret = take && dec_ret;
  assign take_mov = take && dec_mov;
  assign take_opt = take && dec_opt;
  assign take_nop = take && dec_nop;

  // State sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // RULE3: second cycle flush
        if (take_ret) begin
          state_nxt = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Work register next value
  always @* begin
    work_nxt = work_r;
    // RULE1: literal into work
    if (take_ret) begin
      work_nxt = dec_lit;
    end
    // RULE5: literal into work
    if (take_mov) begin
      work_nxt = dec_lit;
    end
  end

  // Option register next value
  always @* begin
    option_nxt = option_r;
    // RULE4: work into option
    if (take_opt) begin
      option_nxt = work_r;
    end
  end

  // Counter reload value
  always @* begin
    pc_nxt = pc_r;
    // RULE2: pop stack top
    if (take_ret) begin
      pc_nxt = i_stack_top_entry;
    end
  end

  // Counter reload pulse
  always @* begin
    // RULE2: one-cycle reload pulse
    pc_load_nxt = take_ret;
  end

  // Stack pop pulse
  always @* begin
    // RULE2: one-cycle pop pulse
    stack_pop_nxt = take_ret;
  end

  // Busy level
  always @* begin
    // RULE3: busy in second cycle
    busy_nxt = (state_nxt == ST_FLUSH);
  end

  // Done pulse
  always @* begin
    done_nxt = 1'h0;
    // RULE3: return ends second cycle
    if (state_r == ST_FLUSH) begin
      done_nxt = 1'h1;
    end
    // RULE5: one-cycle kinds finish
    if (take_mov || take_opt || take_nop) begin
      done_nxt = 1'h1;
    end
  end

  // State register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Work register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      work_r <= `LRO_RST_WORK;
    end else begin
      work_r <= work_nxt;
    end
  end

  // Option register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      option_r <= `LRO_RST_OPTION;
    end else begin
      option_r <= option_nxt;
    end
  end

  // Counter value register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pc_r <= {PC_W{1'h0}};
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Reload pulse register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pc_load_r <= 1'h0;
    end else begin
      pc_load_r <= pc_load_nxt;
    end
  end

  // Pop pulse register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stack_pop_r <= 1'h0;
    end else begin
      stack_pop_r <= stack_pop_nxt;
    end
  end

  // Busy register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy_r <= 1'h0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // Done register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      done_r <= 1'h0;
    end else begin
      done_r <= done_nxt;
    end
  end

  // Outputs straight from registers
  assign o_work      = work_r;
  assign o_option    = option_r;
  assign o_pc        = pc_r;
  assign o_pc_load   = pc_load_r;
  assign o_stack_pop = stack_pop_r;
  assign o_busy      = busy_r;
  assign o_done      = done_r;
endmodule

//--- tb/lro_exec_assertions.sv
// Checker for the executor
`timescale 1ns/1ps
module lro_chk #(parameter PC_W = 11) (input wire i_clk, i_rst_n, i_valid, input wire [11:0] i_word,
  input wire [PC_W-1:0] i_stack_top_entry, input wire [7:0] o_work, o_option, input wire [PC_W-1:0] o_pc,
  input wire o_pc_load, o_stack_pop, o_busy, o_done);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_ret; i_valid && !o_busy && i_word[11:8] == 4'h8; endsequence
  sequence s_tail; (o_busy && !o_done) ##1 (o_done && !o_busy); endsequence
  property p_w; s_ret |=> o_work == $past(i_word[7:0]); endproperty
  a_w: assert property (p_w) else $error("work wrong");
  property p_pc; s_ret |=> o_pc == $past(i_stack_top_entry) && o_pc_load && o_stack_pop; endproperty
  a_pc: assert property (p_pc) else $error("pc wrong");
  property p_two; s_ret |=> s_tail; endproperty
  a_two: assert property (p_two) else $error("timing wrong");
  property p_opt; i_valid && !o_busy && i_word == 12'h002 |=> o_option == $past(o_work) && o_done; endproperty
  a_opt: assert property (p_opt) else $error("option wrong");
  property p_mov; i_valid && !o_busy && i_word[11:8] == 4'hc |=> o_work == $past(i_word[7:0]) && o_done; endproperty
  a_mov: assert property (p_mov) else $error("move wrong");
endmodule
bind lro_exec lro_chk #(.PC_W(PC_W)) u_chk (.*);

//--- tb/tb.sv
// Testbench for the executor
`timescale 1ns/1ps
module tb;
  reg         clk = 0, rst_n = 0, vld = 0;
  reg  [11:0] wd = 0;
  reg  [10:0] stk = 0;
  wire [7:0]  work, opt;
  wire [10:0] pc;
  wire        pl, sp, bsy, dn;
  integer     errors = 0, num_checks = 0;
  lro_exec DUT (.i_clk(clk), .i_rst_n(rst_n), .i_valid(vld), .i_word(wd), .i_stack_top_entry(stk),
    .o_work(work), .o_option(opt), .o_pc(pc), .o_pc_load(pl), .o_stack_pop(sp), .o_busy(bsy), .o_done(dn));
  initial forever #2 clk = ~clk;
  task chk(input [31:0] n, input [15:0] e, s);
    begin
      num_checks = num_checks + 1;
      if (e !== s) begin
        errors = errors + 1;
        $display("Error %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  task issue(input [11:0] w);
    begin
      @(posedge clk) begin vld <= 1; wd <= w; end
      @(posedge clk) vld <= 0;
      #1;
    end
  endtask
  task t_mov;
    begin issue(12'hc5a); chk("work", 16'h5a, work); chk("done", 16'h1, dn); end
  endtask
  task t_opt;
    begin issue(12'h002); chk("opt", 16'h5a, opt); chk("work", 16'h5a, work); end
  endtask
  task t_nop;
    begin issue(12'h000); chk("work", 16'h5a, work); chk("done", 16'h1, dn); end
  endtask
  task t_ret;
    begin
      @(posedge clk) stk <= 11'h3a5;
      issue(12'h8c3);
      chk("work", 16'hc3, work);
      chk("pc", 16'h3a5, pc);
      chk("flag", 16'he, {pl, sp, bsy, dn});
      @(posedge clk) #1;
      chk("flag", 16'h1, {pl, sp, bsy, dn});
    end
  endtask
  task t_b2b;
    begin
      @(posedge clk) begin vld <= 1; wd <= 12'hc3c; end
      @(posedge clk) wd <= 12'h002;
      @(posedge clk) vld <= 0;
      #1;
      chk("opt", 16'h3c, opt);
      chk("done", 16'h1, dn);
      chk("work", 16'h3c, work);
    end
  endtask
  task t_busy;
    begin
      @(posedge clk) begin vld <= 1; wd <= 12'h811; stk <= 11'h155; end
      @(posedge clk) wd <= 12'hc77;
      @(posedge clk) vld <= 0;
      #1;
      chk("work", 16'h11, work);
      chk("flag", 16'h1, {pl, sp, bsy, dn});
      chk("pc", 16'h155, pc);
    end
  endtask
  task t_unk;
    begin
      issue(12'h001);
      chk("done", 16'h0, dn);
      chk("work", 16'h11, work);
      chk("opt", 16'h3c, opt);
    end
  endtask
  task t_reset;
    begin
      @(posedge clk) rst_n <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      #1;
      chk("work", 16'h0, work);
      chk("opt", 16'hff, opt);
      chk("pc", 16'h0, pc);
      chk("flag", 16'h0, {pl, sp, bsy, dn});
      issue(12'hca5);
      chk("work", 16'ha5, work);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    #1 chk("opt", 16'hff, opt);
    t_mov;
    t_opt;
    t_nop;
    t_ret;
    t_mov;
    t_b2b;
    t_busy;
    t_unk;
    t_reset;
    report_and_stop;
  end
endmodule
